// >>> cgp_clk_gate.v
`timescale 1ns/1ps
`default_nettype none

module cgp_clk_gate (
  input wire clk_in, // Clock to be gated
  input wire run, // High lets the clock through
  output wire clk_out // Gated clock
);

  reg run_lat;

  // Enable is taken on the falling edge, so it only moves while the clock is low
  // and no runt pulse leaves; a flop keeps the path free of an open latch
  always @(negedge clk_in) begin
    run_lat <= run;
  end

  assign clk_out = clk_in & run_lat;

endmodule // cgp_clk_gate

`default_nettype wire

// >>> cgp_clock_ctrl.v
// Function
// - Gate A bits stop timer and port clocks
// - Gate A bits 12 and 11 read zero
// - Gate B bits stop listed peripheral clocks
// - Gate B reserved bits read zero
// - Key 0xC1 unlocks writes to other registers
// - Key resets to 0xC1, upper bits zero
// - Gear gives fc divided 1,2,4,8,16
// - Prescaler divides source by 1 to 32
// - Reset: internal and low oscillators run, rest off
// - After reset all clocks equal internal oscillator
// - Source select picks internal or external oscillator
// - PLL-use bit picks oscillator or PLL clock
// - Prescaler source chosen by peripheral source bit
// - Warm-up timer holds off deep stop exit
// - Warm-up selects: source internal/external, speed high/low
// - Start bit begins count; flag high while counting
// - Gear codes 000,100,101,110,111 map to divisions
`timescale 1ns/1ps
`default_nettype none
`include "cgp_clock_map.vh"

module cgp_clock_ctrl #(
  parameter WARMUP_WIDTH = 16 // Width of the warm-up count
) (
  input wire pclk, // Bus and system clock
  input wire presetn, // Asynchronous reset, active low
  input wire ce, // Clock enable, freezes all state when low
  input wire psel, // APB select
  input wire penable, // APB access phase
  input wire pwrite, // APB write
  input wire [7:0] paddr, // APB byte address
  input wire [31:0] pwdata, // APB write data
  output wire pready, // APB ready
  output reg [31:0] prdata, // APB read data
  output wire pslverr, // APB error on unmapped address
  input wire wu_tick_int_high, // Internal high oscillator, asynchronous
  input wire wu_tick_ext_high, // External high oscillator, asynchronous
  input wire wu_tick_low, // Low-speed oscillator, asynchronous
  input wire deep_stop_exit, // One-cycle request to leave a deep stop
  output wire warmup_hold, // High while the wake-up is held off
  output wire oscillator_source_select, // 1 selects external high source
  output wire external_source_kind, // 1 crystal, 0 clock input
  output wire external_high_en, // External high oscillator runs
  output wire internal_high_en, // Internal high oscillator runs
  output wire external_low_en, // External low oscillator runs
  output wire pll_en, // PLL runs
  output wire pll_use_select, // 1 selects PLL as high-speed clock
  output reg sys_tick, // System clock strobe from the gear
  output reg prescale_tick, // Prescaler output strobe
  output wire [31:0] gated_clk_a, // Gated clocks for gate A units
  output wire [31:0] gated_clk_b // Gated clocks for gate B units
);

  // ----------------------------------------------------------------
  // Decode functions
  // ----------------------------------------------------------------

  // Reserved gear codes fall back to no division
  function [2:0] gear_shift;
    input [2:0] code;
    begin
      case (code)
        3'b100: gear_shift = 3'd1;
        3'b101: gear_shift = 3'd2;
        3'b110: gear_shift = 3'd3;
        3'b111: gear_shift = 3'd4;
        default: gear_shift = 3'd0;
      endcase
    end
  endfunction

  // Prescaler codes 0..5 divide by 1..32, reserved codes divide by 1
  function [2:0] prescale_shift;
    input [2:0] code;
    begin
      if (code <= 3'd5) begin
        prescale_shift = code;
      end else begin
        prescale_shift = 3'd0;
      end
    end
  endfunction

  // Low bits of a divider counter that must be zero for a strobe
  function [4:0] shift_mask;
    input [2:0] sh;
    begin
      shift_mask = 5'h1F >> (3'd5 - sh);
    end
  endfunction

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  reg [31:0] system_ctrl_r;
  reg [31:0] osc_ctrl_r;
  reg [31:0] pll_ctrl_r;
  reg [31:0] peripheral_clock_gate_a_r;
  reg [31:0] peripheral_clock_gate_b_r;
  reg [7:0] clock_register_write_lock_r;
  reg warmup_active_r;
  reg [WARMUP_WIDTH-1:0] warmup_cnt_r;
  reg [4:0] gear_cnt_r;
  reg [4:0] pre_cnt_r;
  reg [2:0] sync1_r;
  reg [2:0] sync2_r;
  reg [2:0] sync3_r;

  wire access_done;
  wire wr_en;
  wire unlocked;
  wire addr_hit;
  wire [31:0] rd_value;

  // Zero wait states; stall the master while the block is frozen
  assign pready = ce;
  assign access_done = psel & penable & ce;
  assign wr_en = access_done & pwrite & ~pslverr;
  assign unlocked = (clock_register_write_lock_r == `CGP_UNLOCK_KEY);

  assign addr_hit = (paddr == `CGP_OFF_SYSTEM_CTRL) | (paddr == `CGP_OFF_OSC_CTRL) |
    (paddr == `CGP_OFF_PLL_CTRL) | (paddr == `CGP_OFF_GATE_A) |
    (paddr == `CGP_OFF_GATE_B) | (paddr == `CGP_OFF_WRITE_LOCK);
  assign pslverr = psel & penable & ~addr_hit;

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------

  // Locked writes are dropped silently; the key register is always open
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      system_ctrl_r <= `CGP_RST_SYSTEM_CTRL;
      osc_ctrl_r <= `CGP_RST_OSC_CTRL;
      pll_ctrl_r <= `CGP_RST_PLL_CTRL;
      peripheral_clock_gate_a_r <= `CGP_RST_GATE;
      peripheral_clock_gate_b_r <= `CGP_RST_GATE;
      clock_register_write_lock_r <= `CGP_RST_WRITE_LOCK;
    end else if (wr_en) begin
      if (paddr == `CGP_OFF_WRITE_LOCK) begin
        clock_register_write_lock_r <= pwdata[7:0];
      end else if (unlocked) begin
        case (paddr)
          `CGP_OFF_SYSTEM_CTRL: begin
            system_ctrl_r <= pwdata & `CGP_MASK_SYSTEM_CTRL;
          end
          `CGP_OFF_OSC_CTRL: begin
            osc_ctrl_r <= pwdata & `CGP_MASK_OSC_CTRL;
          end
          `CGP_OFF_PLL_CTRL: begin
            pll_ctrl_r <= pwdata & `CGP_MASK_PLL_CTRL;
          end
          `CGP_OFF_GATE_A: begin
            peripheral_clock_gate_a_r <= pwdata & `CGP_MASK_GATE_A;
          end
          `CGP_OFF_GATE_B: begin
            peripheral_clock_gate_b_r <= pwdata & `CGP_MASK_GATE_B;
          end
          default: begin
            system_ctrl_r <= system_ctrl_r;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------

  // Start bit always reads zero; the active flag shows the live timer
  assign rd_value =
    (paddr == `CGP_OFF_SYSTEM_CTRL) ? system_ctrl_r :
    (paddr == `CGP_OFF_OSC_CTRL) ? (osc_ctrl_r |
      ({31'd0, warmup_active_r} << `CGP_OSC_WU_ACTIVE_BIT)) :
    (paddr == `CGP_OFF_PLL_CTRL) ? pll_ctrl_r :
    (paddr == `CGP_OFF_GATE_A) ? peripheral_clock_gate_a_r :
    (paddr == `CGP_OFF_GATE_B) ? peripheral_clock_gate_b_r :
    (paddr == `CGP_OFF_WRITE_LOCK) ? {24'd0, clock_register_write_lock_r} : 32'd0;

  // Data is caught during setup so the access phase ends at once
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (ce && psel && !penable && !pwrite) begin
      prdata <= rd_value;
    end
  end

  // ----------------------------------------------------------------
  // Clock source selects
  // ----------------------------------------------------------------
  assign oscillator_source_select = osc_ctrl_r[`CGP_OSC_SOURCE_SEL_BIT];
  assign external_source_kind = osc_ctrl_r[`CGP_OSC_EXT_KIND_BIT];
  assign external_high_en = osc_ctrl_r[`CGP_OSC_EXT_HIGH_EN_BIT];
  assign internal_high_en = osc_ctrl_r[`CGP_OSC_INT_HIGH_EN_BIT];
  assign external_low_en = osc_ctrl_r[`CGP_OSC_EXT_LOW_EN_BIT];
  assign pll_en = pll_ctrl_r[`CGP_PLL_ENABLE_BIT];
  assign pll_use_select = pll_ctrl_r[`CGP_PLL_USE_BIT];

  // ----------------------------------------------------------------
  // Gear divider and prescaler
  // ----------------------------------------------------------------
  wire [2:0] gear_sh;
  wire [2:0] pre_sh;
  wire gear_hit;
  wire periph_src_tick;
  wire pre_hit;

  // pclk stands in for the high-speed clock; the gear makes strobes
  assign gear_sh = gear_shift(system_ctrl_r[`CGP_SYS_GEAR_LSB +: 3]);
  assign gear_hit = ((gear_cnt_r & shift_mask(gear_sh)) == 5'd0);
  assign periph_src_tick = system_ctrl_r[`CGP_SYS_PERIPH_SRC_BIT] ? 1'b1 : gear_hit;
  assign pre_sh = prescale_shift(system_ctrl_r[`CGP_SYS_PRESCALE_LSB +: 3]);
  assign pre_hit = periph_src_tick && ((pre_cnt_r & shift_mask(pre_sh)) == 5'd0);

  // Changing a division mid-count makes one period irregular, shorter or longer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gear_cnt_r <= 5'd0;
      pre_cnt_r <= 5'd0;
      sys_tick <= 1'b0;
      prescale_tick <= 1'b0;
    end else if (ce) begin
      gear_cnt_r <= gear_cnt_r + 5'd1;
      if (periph_src_tick) begin
        pre_cnt_r <= pre_cnt_r + 5'd1;
      end
      sys_tick <= gear_hit;
      prescale_tick <= pre_hit;
    end
  end

  // ----------------------------------------------------------------
  // Warm-up timer
  // ----------------------------------------------------------------
  wire [2:0] wu_raw;
  wire [2:0] wu_rise;
  wire wu_high_rise;
  wire wu_tick;
  wire wu_start;
  wire [WARMUP_WIDTH-1:0] wu_limit;

  assign wu_raw = {wu_tick_low, wu_tick_ext_high, wu_tick_int_high};

  // Oscillator inputs pass two flops; edges are found after that
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= 3'b000;
      sync2_r <= 3'b000;
      sync3_r <= 3'b000;
    end else if (ce) begin
      sync1_r <= wu_raw;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_edge
      assign wu_rise[gi] = sync2_r[gi] & ~sync3_r[gi];
    end
  endgenerate

  assign wu_high_rise = osc_ctrl_r[`CGP_OSC_WU_SOURCE_BIT] ? wu_rise[1] : wu_rise[0];
  assign wu_tick = osc_ctrl_r[`CGP_OSC_WU_SPEED_BIT] ? wu_rise[2] : wu_high_rise;
  assign wu_start = deep_stop_exit | (wr_en && unlocked && (paddr == `CGP_OFF_OSC_CTRL) &&
    pwdata[`CGP_OSC_WU_START_BIT]);
  assign wu_limit = osc_ctrl_r[`CGP_OSC_WU_COUNT_LSB +: WARMUP_WIDTH];

  // A start during a count restarts it; count 0 ends at the first tick
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      warmup_active_r <= 1'b0;
      warmup_cnt_r <= {WARMUP_WIDTH{1'b0}};
    end else if (ce) begin
      if (wu_start) begin
        warmup_active_r <= 1'b1;
        warmup_cnt_r <= {WARMUP_WIDTH{1'b0}};
      end else if (warmup_active_r && wu_tick) begin
        if (warmup_cnt_r >= wu_limit) begin
          warmup_active_r <= 1'b0;
        end else begin
          warmup_cnt_r <= warmup_cnt_r + {{(WARMUP_WIDTH-1){1'b0}}, 1'b1};
        end
      end
    end
  end

  // Wake-up stays held until the stabilisation count has run out
  assign warmup_hold = warmup_active_r;

  // ----------------------------------------------------------------
  // Peripheral clock gates
  // ----------------------------------------------------------------
  // A set bit stops the unit; reserved bits are stored as zero so never stop
  generate
    for (gi = 0; gi < 32; gi = gi + 1) begin : g_gate
      cgp_clk_gate u_gate_a (
        .clk_in(pclk),
        .run(~peripheral_clock_gate_a_r[gi]),
        .clk_out(gated_clk_a[gi])
      );
      cgp_clk_gate u_gate_b (
        .clk_in(pclk),
        .run(~peripheral_clock_gate_b_r[gi]),
        .clk_out(gated_clk_b[gi])
      );
    end
  endgenerate

endmodule // cgp_clock_ctrl

`default_nettype wire

// >>> cgp_clock_ctrl_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "cgp_clock_map.vh"

module cgp_clock_ctrl_sva #(
  parameter WARMUP_WIDTH = 16 // Warm-up width
) (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset
  input wire logic ce, // Enable
  input wire logic psel, // Select
  input wire logic penable, // Access
  input wire logic pwrite, // Write
  input wire logic [7:0] paddr, // Address
  input wire logic [31:0] pwdata, // Data
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic wu_tick_int_high, // Tick
  input wire logic wu_tick_ext_high, // Tick
  input wire logic wu_tick_low, // Tick
  input wire logic deep_stop_exit, // Wake
  input wire logic warmup_hold, // Hold
  input wire logic oscillator_source_select, // Source
  input wire logic external_high_en, // Osc
  input wire logic internal_high_en, // Osc
  input wire logic external_low_en, // Osc
  input wire logic pll_en, // PLL
  input wire logic pll_use_select, // PLL use
  input wire logic [31:0] gated_clk_a, // Gates
  input wire logic [31:0] gated_clk_b // Gates
);
  // ------
  // Shadow registers
  // ------
  logic [7:0] lock_r;
  logic [31:0] gate_a_r, gate_b_r, gate_a_old_r, gate_b_old_r;
  wire wr_w = psel && penable && pwrite && ce;
  wire open_w = lock_r == `CGP_UNLOCK_KEY;
  wire hit_w = paddr[1:0] == 2'b00 && paddr <= `CGP_OFF_WRITE_LOCK;
  wire quiet_w = !wu_tick_int_high && !wu_tick_ext_high && !wu_tick_low;

  // Old copies follow the gate flop, which holds last cycle's enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_r <= `CGP_RST_WRITE_LOCK;
      gate_a_r <= `CGP_RST_GATE;
      gate_b_r <= `CGP_RST_GATE;
      gate_a_old_r <= `CGP_RST_GATE;
      gate_b_old_r <= `CGP_RST_GATE;
    end else begin
      gate_a_old_r <= gate_a_r;
      gate_b_old_r <= gate_b_r;
      if (wr_w && paddr == `CGP_OFF_WRITE_LOCK) lock_r <= pwdata[7:0];
      if (wr_w && open_w && paddr == `CGP_OFF_GATE_A) gate_a_r <= pwdata;
      if (wr_w && open_w && paddr == `CGP_OFF_GATE_B) gate_b_r <= pwdata;
    end
  end

  // ------
  // Properties
  // ------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_ready; pready == ce; endproperty
  a_ready: assert property (p_ready) else $error("pready not ce");
  property p_err_ok; psel && penable && hit_w |-> !pslverr; endproperty
  a_err_ok: assert property (p_err_ok) else $error("error on mapped");
  property p_err_bad; psel && penable && paddr[1:0] == 2'b00 && !hit_w |-> pslverr; endproperty
  a_err_bad: assert property (p_err_bad) else $error("no error");
  property p_rst_osc; $rose(presetn) |-> internal_high_en && external_low_en
    && !external_high_en && !pll_en; endproperty
  a_rst_osc: assert property (p_rst_osc) else $error("osc after reset");
  property p_rst_sel; $rose(presetn) |-> !oscillator_source_select && !pll_use_select; endproperty
  a_rst_sel: assert property (p_rst_sel) else $error("select after reset");
  property p_gate_low; gated_clk_a == 32'h0000_0000 && gated_clk_b == 32'h0000_0000; endproperty
  a_gate_low: assert property (p_gate_low) else $error("gate high in low phase");
  property p_gate_a; @(negedge pclk) disable iff (!presetn)
    (gated_clk_a & `CGP_MASK_GATE_A) == (~gate_a_old_r & `CGP_MASK_GATE_A); endproperty
  a_gate_a: assert property (p_gate_a) else $error("gate a level");
  property p_gate_b; @(negedge pclk) disable iff (!presetn)
    (gated_clk_b & `CGP_MASK_GATE_B) == (~gate_b_old_r & `CGP_MASK_GATE_B); endproperty
  a_gate_b: assert property (p_gate_b) else $error("gate b level");
  property p_wu_start; deep_stop_exit && ce |=> warmup_hold; endproperty
  a_wu_start: assert property (p_wu_start) else $error("hold not raised");
  property p_wu_hold; (warmup_hold && quiet_w) [*6] |=> warmup_hold; endproperty
  a_wu_hold: assert property (p_wu_hold) else $error("hold ended early");
endmodule // cgp_clock_ctrl_sva

bind cgp_clock_ctrl cgp_clock_ctrl_sva #(.WARMUP_WIDTH(WARMUP_WIDTH)) u_sva (
  .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .wu_tick_int_high(wu_tick_int_high), .wu_tick_ext_high(wu_tick_ext_high),
  .wu_tick_low(wu_tick_low), .deep_stop_exit(deep_stop_exit), .warmup_hold(warmup_hold),
  .oscillator_source_select(oscillator_source_select), .external_high_en(external_high_en),
  .internal_high_en(internal_high_en), .external_low_en(external_low_en), .pll_en(pll_en),
  .pll_use_select(pll_use_select), .gated_clk_a(gated_clk_a), .gated_clk_b(gated_clk_b)
);
`default_nettype wire

// >>> cgp_clock_map.vh
`ifndef CGP_CLOCK_MAP_VH
`define CGP_CLOCK_MAP_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define CGP_OFF_SYSTEM_CTRL 8'h00
`define CGP_OFF_OSC_CTRL 8'h04
`define CGP_OFF_PLL_CTRL 8'h08
`define CGP_OFF_GATE_A 8'h0C
`define CGP_OFF_GATE_B 8'h10
`define CGP_OFF_WRITE_LOCK 8'h14

// ----------------------------------------------------------------
// Reset values and writable masks
// ----------------------------------------------------------------
`define CGP_RST_SYSTEM_CTRL 32'h0000_0000
`define CGP_RST_OSC_CTRL 32'h0800_0018
`define CGP_RST_PLL_CTRL 32'h0000_0000
`define CGP_RST_GATE 32'h0000_0000
`define CGP_RST_WRITE_LOCK 8'hC1
`define CGP_UNLOCK_KEY 8'hC1
`define CGP_MASK_GATE_A 32'h0007_E7FF
`define CGP_MASK_GATE_B 32'hF7FE_7C0F
`define CGP_MASK_SYSTEM_CTRL 32'h0000_1707
`define CGP_MASK_OSC_CTRL 32'hFFFF_031F
`define CGP_MASK_PLL_CTRL 32'h0000_0003

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CGP_SYS_GEAR_LSB 0
`define CGP_SYS_PRESCALE_LSB 8
`define CGP_SYS_PERIPH_SRC_BIT 12
`define CGP_OSC_SOURCE_SEL_BIT 0
`define CGP_OSC_EXT_KIND_BIT 1
`define CGP_OSC_EXT_HIGH_EN_BIT 2
`define CGP_OSC_INT_HIGH_EN_BIT 3
`define CGP_OSC_EXT_LOW_EN_BIT 4
`define CGP_OSC_WU_SPEED_BIT 8
`define CGP_OSC_WU_SOURCE_BIT 9
`define CGP_OSC_WU_START_BIT 14
`define CGP_OSC_WU_ACTIVE_BIT 15
`define CGP_OSC_WU_COUNT_LSB 16
`define CGP_PLL_ENABLE_BIT 0
`define CGP_PLL_USE_BIT 1

`endif

// >>> cgp_testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "cgp_clock_map.vh"

module testbench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic tk_ih = 1'b0;
  logic tk_eh = 1'b0;
  logic tk_lo = 1'b0;
  logic dse = 1'b0;
  logic [1:0] tsel = 2'd0;
  logic [1:0] tcnt = 2'd0;
  logic pready, pslverr, hold, stk, ptk, e;
  logic osel, okind, xh_en, ih_en, xl_en, pll_en, puse;
  logic [31:0] prdata, gca, gcb, r, v, ga, gb, sv;
  int error_cnt = 0;
  int checked = 0;
  int seed = 32'h415c;
  int i, n;

  cgp_clock_ctrl #(.WARMUP_WIDTH(16)) dut (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .wu_tick_int_high(tk_ih), .wu_tick_ext_high(tk_eh),
    .wu_tick_low(tk_lo), .deep_stop_exit(dse), .warmup_hold(hold),
    .oscillator_source_select(osel), .external_source_kind(okind),
    .external_high_en(xh_en), .internal_high_en(ih_en), .external_low_en(xl_en),
    .pll_en(pll_en), .pll_use_select(puse), .sys_tick(stk), .prescale_tick(ptk),
    .gated_clk_a(gca), .gated_clk_b(gcb)
  );

  always #12.5 pclk = ~pclk;

  // Stand-in oscillators: only the chosen one toggles, every four cycles
  always @(posedge pclk) begin
    tcnt <= tcnt + 2'd1;
    if (tcnt == 2'd0) begin
      tk_ih <= tsel == 2'd1 && !tk_ih;
      tk_eh <= tsel == 2'd2 && !tk_eh;
      tk_lo <= tsel == 2'd3 && !tk_lo;
    end
  end

  // ------
  // Helpers
  // ------
  task automatic conclude;
    if (error_cnt == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    checked++;
    if (g !== x) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, x, g);
    end
  endtask

  // Setup, then access held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("pready", 1, pready);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x, input string nm);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, x, r);
    chk("pslverr", 0, e);
  endtask

  // Second interval between strobes is the settled period
  task automatic period(input logic s);
    for (int k = 0; k < 2; k++) begin
      n = 0;
      do begin
        @(posedge pclk);
        #1;
        n++;
      end while ((s ? ptk : stk) !== 1'b1 && n < 100);
    end
  endtask

  task automatic wait_hold;
    n = 0;
    while (hold !== 1'b0 && n < 400) begin
      @(posedge pclk);
      #1;
      n++;
    end
    chk("warmup end", 0, hold);
  endtask

  function automatic int gear_div(input logic [2:0] c);
    return c[2] ? 2 << c[1:0] : 1; // Reserved codes act as undivided
  endfunction

  function automatic int pre_div(input logic [2:0] c);
    return c <= 3'd5 ? 1 << c : 1;
  endfunction

  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    conclude;
  end

  // ------
  // Scenarios
  // ------
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(`CGP_OFF_SYSTEM_CTRL, `CGP_RST_SYSTEM_CTRL, "sys reset");
    rd(`CGP_OFF_OSC_CTRL, `CGP_RST_OSC_CTRL, "osc reset");
    rd(`CGP_OFF_PLL_CTRL, `CGP_RST_PLL_CTRL, "pll reset");
    rd(`CGP_OFF_GATE_A, 32'h0000_0000, "gate a reset");
    rd(`CGP_OFF_GATE_B, 32'h0000_0000, "gate b reset");
    rd(`CGP_OFF_WRITE_LOCK, 32'h0000_00C1, "lock reset");
    chk("reset pins", 7'h0C, {osel, okind, xh_en, ih_en, xl_en, pll_en, puse});
    apb(1'b1, `CGP_OFF_OSC_CTRL, 32'h0000_001B);
    apb(1'b1, `CGP_OFF_PLL_CTRL, 32'h0000_0003);
    #1;
    chk("select pins", 4'hF, {osel, okind, pll_en, puse});
    for (i = 0; i < 6; i++) begin
      v = $random(seed);
      apb(1'b1, `CGP_OFF_SYSTEM_CTRL, v);
      sv = v & `CGP_MASK_SYSTEM_CTRL;
      rd(`CGP_OFF_SYSTEM_CTRL, sv, "sys field");
    end
    ga = 32'h0000_0000;
    gb = 32'h0000_0000;
    // Gate bits are only ever added, never cleared
    for (i = 0; i < 6; i++) begin
      v = $random(seed);
      apb(1'b1, `CGP_OFF_GATE_A, ga | v);
      ga = (ga | v) & `CGP_MASK_GATE_A;
      rd(`CGP_OFF_GATE_A, ga, "gate a");
      v = $random(seed);
      apb(1'b1, `CGP_OFF_GATE_B, gb | v);
      gb = (gb | v) & `CGP_MASK_GATE_B;
      rd(`CGP_OFF_GATE_B, gb, "gate b");
    end
    v = $random(seed);
    if (v[7:0] == 8'hC1) v[0] = 1'b0;
    apb(1'b1, `CGP_OFF_WRITE_LOCK, v);
    rd(`CGP_OFF_WRITE_LOCK, {24'h0, v[7:0]}, "lock key");
    apb(1'b1, `CGP_OFF_GATE_B, 32'hFFFF_FFFF);
    rd(`CGP_OFF_GATE_B, gb, "locked gate");
    apb(1'b1, `CGP_OFF_SYSTEM_CTRL, ~sv);
    rd(`CGP_OFF_SYSTEM_CTRL, sv, "locked sys");
    apb(1'b1, `CGP_OFF_WRITE_LOCK, 32'hFFFF_FFC1);
    rd(`CGP_OFF_WRITE_LOCK, 32'h0000_00C1, "unlock key");
    apb(1'b1, `CGP_OFF_GATE_B, 32'hFFFF_FFFF);
    rd(`CGP_OFF_GATE_B, `CGP_MASK_GATE_B, "gate b all");
    ce <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("pready frozen", 0, pready);
    ce <= 1'b1;
    apb(1'b1, 8'h18, 32'hFFFF_FFFF);
    chk("unmapped err", 1, e);
    apb(1'b0, 8'h18, 32'h0000_0000);
    chk("unmapped data", 0, r);
    for (i = 0; i < 8; i++) begin
      apb(1'b1, `CGP_OFF_SYSTEM_CTRL, 32'h0000_1000 | 32'(i << 8) | 32'(i));
      period(1'b0);
      chk("gear period", gear_div(3'(i)), n);
      period(1'b1);
      chk("prescale period", pre_div(3'(i)), n);
    end
    apb(1'b1, `CGP_OFF_SYSTEM_CTRL, 32'h0000_0104);
    period(1'b1);
    chk("gear fed prescale", 4, n);
    // Wrong oscillator must not advance the count, the chosen one must
    for (i = 0; i < 3; i++) begin
      v = i == 0 ? 32'h0003_0018 : (i == 1 ? 32'h0003_0218 : 32'h0003_0118);
      tsel <= i == 0 ? 2'd2 : 2'd1;
      apb(1'b1, `CGP_OFF_OSC_CTRL, v);
      apb(1'b1, `CGP_OFF_OSC_CTRL, v | 32'h0000_4000);
      repeat (60) @(posedge pclk);
      rd(`CGP_OFF_OSC_CTRL, v | 32'h0000_8000, "warmup busy");
      tsel <= 2'(i + 1);
      wait_hold;
      rd(`CGP_OFF_OSC_CTRL, v, "warmup done");
    end
    @(posedge pclk);
    dse <= 1'b1;
    @(posedge pclk);
    dse <= 1'b0;
    #1;
    chk("hold on exit", 1, hold);
    wait_hold;
    conclude;
  end
endmodule // testbench
`default_nettype wire
